/* File: design/pwr_mode_pkg.sv */
// Constants for the global power-mode controller.
// Assumes a 200 MHz ref_clk; all counts derive from that rate.
package pwr_mode_pkg;
   localparam int CLK_MHZ            = 200;
   // Wake times in microseconds and their cycle counts
   localparam int SLEEP_WAKE_US      = 15;
   localparam int SLEEP_WAKE_CYC     = SLEEP_WAKE_US * CLK_MHZ;
   localparam int HIB_WAKE_US        = 100;
   localparam int HIB_WAKE_CYC       = (HIB_WAKE_US * CLK_MHZ) - 1;
   // Boost converter switching, 400 kHz from 200 MHz
   localparam int BOOST_SW_KHZ       = 400;
   localparam int BOOST_HALF_CYC     = (CLK_MHZ * 1000) / (BOOST_SW_KHZ * 2);
   // Boost output code: 1.8 V to 5.0 V in 100 mV steps
   localparam int BOOST_MV_MIN       = 1800;
   localparam int BOOST_MV_MAX       = 5000;
   localparam int BOOST_MV_STEP      = 100;
   localparam logic [5:0] BOOST_CODE_MAX =
      6'((BOOST_MV_MAX - BOOST_MV_MIN) / BOOST_MV_STEP);
   // Startup oscillator selection
   localparam logic [1:0] OSC_SEL_48 = 2'h1;
   localparam logic [1:0] OSC_SEL_12 = 2'h2;
   // Resource bit of the processor inside a template
   localparam int CPU_BIT            = 0;
   // Mode request codes
   localparam logic [1:0] REQ_ALT    = 2'h1;
   localparam logic [1:0] REQ_SLEEP  = 2'h2;
   localparam logic [1:0] REQ_HIB    = 2'h3;
   // Resources left alive in sleep (forced set)
   localparam logic [15:0] SLEEP_KEEP = 16'h0000;
   typedef enum logic [2:0] {
      ST_ACTIVE, ST_ALT, ST_SLEEP, ST_HIB, ST_WAKE
   } pmode_t;
endpackage

/* File: design/wake_timer.sv */
// Down counter timing the resume from sleep or hibernate.
// Assumes start is a one-cycle pulse with a load value.
`timescale 1ns/1ps
`default_nettype none
module wake_timer #(
   parameter int W = 16
) (
   // Clock and reset
   input  wire logic         ref_clk,
   input  wire logic         rst,
   // Control
   input  wire logic         start,
   input  wire logic [W-1:0] load,
   // Status
   output logic              done
);
   logic [W-1:0] count;
   logic         run;

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         count <= '0;
         run   <= 1'b0;
         done  <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         if (start)
         begin
            count <= load;
            run   <= 1'b1;
         end
         else if (run)
         begin
            if (count == '0)
            begin
               run  <= 1'b0;
               done <= 1'b1;
            end
            else
               count <= count - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

/* File: design/power_mode_controller.sv */
// Global power-mode controller: modes, clock gating, wakeup, boost control.
// Assumes synchronous inputs on ref_clk and firmware driving the plain ports.
`timescale 1ns/1ps
`default_nettype none
module power_mode_controller #(
   parameter int N_RES     = 16,
   parameter int N_IRQ     = 8,
   parameter int SLEEP_CYC = pwr_mode_pkg::SLEEP_WAKE_CYC,
   parameter int HIB_CYC   = pwr_mode_pkg::HIB_WAKE_CYC
) (
   // Clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst,
   // Templates and mode request
   input  wire logic [N_RES-1:0] active_template,
   input  wire logic [N_RES-1:0] alt_template,
   input  wire logic [1:0]       mode_req,
   input  wire logic             mode_req_wr,
   input  wire logic             cpu_off_req,
   // Wakeup sources
   input  wire logic [N_IRQ-1:0] irq_pending,
   input  wire logic [N_IRQ-1:0] irq_enable,
   input  wire logic             supervisor_irq,
   input  wire logic             timewheel_irq,
   input  wire logic             pin_irq,
   input  wire logic             external_reset_pin_n,
   input  wire logic             watchdog_timer,
   input  wire logic             precise_low_voltage_reset,
   // Boost and startup configuration
   input  wire logic [5:0]       boost_vsel,
   input  wire logic             boost_standby_req,
   input  wire logic             fast_startup,
   // Status and controls
   output logic [2:0]            global_mode,
   output logic [N_RES-1:0]      res_enable,
   output logic [N_RES-1:0]      clk_gate_en,
   output logic                  cpu_enable,
   output logic                  retain_hold,
   output logic [5:0]            boost_code,
   output logic                  boost_active,
   output logic                  boost_clk,
   output logic [1:0]            startup_osc_sel
);
   pwr_mode_pkg::pmode_t mode;
   logic                 wake_start;
   logic [15:0]          wake_load;
   logic                 wake_done;
   logic                 cpu_self_off;
   logic                 started;
   logic [7:0]           boost_div;

   // Level wake sources; reset type wakes from the active-low reset pin or the active-high watchdog and low-voltage inputs
   logic reset_wake;
   logic irq_wake;
   assign reset_wake = !external_reset_pin_n || watchdog_timer
                       || precise_low_voltage_reset;
   assign irq_wake = |(irq_pending & irq_enable) || supervisor_irq
                     || timewheel_irq || pin_irq;

   wake_timer #(.W(16)) u_wake_timer (
      .ref_clk (ref_clk),
      .rst     (rst),
      .start   (wake_start),
      .load    (wake_load),
      .done    (wake_done)
   );

   // Mode sequencer
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         mode       <= pwr_mode_pkg::ST_ACTIVE;
         wake_start <= 1'b0;
         wake_load  <= '0;
      end
      else
      begin
         wake_start <= 1'b0;
         unique case (mode)
            pwr_mode_pkg::ST_ACTIVE, pwr_mode_pkg::ST_ALT:
            begin
               if (mode == pwr_mode_pkg::ST_ALT && (irq_wake || reset_wake))
                  mode <= pwr_mode_pkg::ST_ACTIVE;
               else if (mode_req_wr)
               begin
                  if (mode_req == pwr_mode_pkg::REQ_ALT)
                     mode <= pwr_mode_pkg::ST_ALT;
                  else if (mode_req == pwr_mode_pkg::REQ_SLEEP)
                     mode <= pwr_mode_pkg::ST_SLEEP;
                  else if (mode_req == pwr_mode_pkg::REQ_HIB)
                     mode <= pwr_mode_pkg::ST_HIB;
               end
            end
            pwr_mode_pkg::ST_SLEEP:
            begin
               if (irq_wake || reset_wake)
               begin
                  mode       <= pwr_mode_pkg::ST_WAKE;
                  wake_start <= 1'b1;
                  wake_load  <= 16'(SLEEP_CYC - 1);
               end
            end
            pwr_mode_pkg::ST_HIB:
            begin
               // Reset pin still acts as a real reset elsewhere
               if (pin_irq)
               begin
                  mode       <= pwr_mode_pkg::ST_WAKE;
                  wake_start <= 1'b1;
                  // Load, count-out and done add three cycles; total stays HIB_CYC
                  wake_load  <= 16'(HIB_CYC - 3);
               end
            end
            pwr_mode_pkg::ST_WAKE:
            begin
               if (wake_done)
                  mode <= pwr_mode_pkg::ST_ACTIVE;
            end
         endcase
      end
   end

   // Processor self-disable, cleared by the next wakeup
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         cpu_self_off <= 1'b0;
      else if (irq_wake || reset_wake || mode == pwr_mode_pkg::ST_WAKE)
         cpu_self_off <= 1'b0;
      else if (cpu_off_req)
         cpu_self_off <= 1'b1;
   end

   // Resource enables and clock gates follow the active or alt template; sleep, hibernate and wake force SLEEP_KEEP
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         res_enable  <= '1;
         clk_gate_en <= '1;
         cpu_enable  <= 1'b1;
         global_mode <= 3'h0;
         retain_hold <= 1'b0;
      end
      else
      begin
         global_mode <= mode;
         retain_hold <= (mode == pwr_mode_pkg::ST_HIB);
         unique case (mode)
            pwr_mode_pkg::ST_ACTIVE:
            begin
               res_enable  <= active_template;
               clk_gate_en <= active_template;
               cpu_enable  <= active_template[pwr_mode_pkg::CPU_BIT] && !cpu_self_off;
            end
            pwr_mode_pkg::ST_ALT:
            begin
               res_enable  <= alt_template;
               clk_gate_en <= alt_template;
               cpu_enable  <= alt_template[pwr_mode_pkg::CPU_BIT] && !cpu_self_off;
            end
            pwr_mode_pkg::ST_SLEEP, pwr_mode_pkg::ST_HIB, pwr_mode_pkg::ST_WAKE:
            begin
               res_enable  <= N_RES'(pwr_mode_pkg::SLEEP_KEEP);
               clk_gate_en <= N_RES'(pwr_mode_pkg::SLEEP_KEEP);
               cpu_enable  <= 1'b0;
            end
         endcase
         if (mode == pwr_mode_pkg::ST_WAKE && wake_done)
            cpu_enable <= 1'b1;
      end
   end

   // Boost output code, clamped to the legal range
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         boost_code <= 6'h00;
      else if (boost_vsel > pwr_mode_pkg::BOOST_CODE_MAX)
         boost_code <= pwr_mode_pkg::BOOST_CODE_MAX;
      else
         boost_code <= boost_vsel;
   end

   // Boost mode: standby only honoured in sleep
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         boost_active <= 1'b1;
      else
         boost_active <= !(boost_standby_req
                           && mode == pwr_mode_pkg::ST_SLEEP);
   end

   // 400 kHz switching clock, stopped in standby
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         boost_div <= 8'h00;
         boost_clk <= 1'b0;
      end
      else if (!boost_active)
      begin
         boost_div <= 8'h00;
         boost_clk <= 1'b0;
      end
      else if (boost_div == 8'(pwr_mode_pkg::BOOST_HALF_CYC - 1))
      begin
         boost_div <= 8'h00;
         boost_clk <= !boost_clk;
      end
      else
         boost_div <= boost_div + 8'h01;
   end

   // Startup oscillator caught once after reset release
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         started         <= 1'b0;
         startup_osc_sel <= 2'h0;
      end
      else if (!started)
      begin
         started         <= 1'b1;
         startup_osc_sel <= fast_startup ? pwr_mode_pkg::OSC_SEL_48
                                         : pwr_mode_pkg::OSC_SEL_12;
      end
   end

   // Resume cycle count and origin, kept only for the resume-time checks
   logic        from_hib;
   logic [15:0] wake_cycles;

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         from_hib    <= 1'b0;
         wake_cycles <= 16'h0000;
      end
      else if (mode == pwr_mode_pkg::ST_WAKE)
         wake_cycles <= wake_cycles + 16'h0001;
      else
      begin
         from_hib    <= (mode == pwr_mode_pkg::ST_HIB);
         wake_cycles <= 16'h0000;
      end
   end

   AST_SLEEP_WAKE_TIME: assert property (@(posedge ref_clk) disable iff (rst)
      (mode == pwr_mode_pkg::ST_SLEEP && (irq_wake || reset_wake))
      |=> (mode == pwr_mode_pkg::ST_WAKE)[*8])
      else $error("sleep resume too short");
   AST_HIB_ONLY_PIN: assert property (@(posedge ref_clk) disable iff (rst)
      (mode == pwr_mode_pkg::ST_HIB && !pin_irq) |=> mode == pwr_mode_pkg::ST_HIB)
      else $error("hibernate left without pin interrupt");
   AST_WAKE_CPU_ON: assert property (@(posedge ref_clk) disable iff (rst)
      (mode == pwr_mode_pkg::ST_WAKE && wake_done) |=> cpu_enable
      && mode == pwr_mode_pkg::ST_ACTIVE)
      else $error("wakeup did not enable cpu");
   AST_ACTIVE_TEMPLATE: assert property (@(posedge ref_clk) disable iff (rst)
      (mode == pwr_mode_pkg::ST_ACTIVE && $stable(mode))
      |=> res_enable == $past(active_template))
      else $error("active template not applied");
   AST_CLK_GATE: assert property (@(posedge ref_clk) disable iff (rst)
      clk_gate_en == res_enable)
      else $error("clock gate differs from enable");
   AST_SLEEP_DISABLE: assert property (@(posedge ref_clk) disable iff (rst)
      mode == pwr_mode_pkg::ST_SLEEP |=> res_enable == N_RES'(pwr_mode_pkg::SLEEP_KEEP))
      else $error("sleep left resources on");
   AST_BOOST_ACTIVE: assert property (@(posedge ref_clk) disable iff (rst)
      (mode == pwr_mode_pkg::ST_ACTIVE || mode == pwr_mode_pkg::ST_ALT)
      ##1 $stable(mode) |-> boost_active)
      else $error("boost not active in active mode");
   AST_BOOST_RANGE: assert property (@(posedge ref_clk) disable iff (rst)
      boost_code <= pwr_mode_pkg::BOOST_CODE_MAX)
      else $error("boost code out of range");
   AST_NO_UNREQ_SLEEP: assert property (@(posedge ref_clk) disable iff (rst)
      (mode == pwr_mode_pkg::ST_ACTIVE && !mode_req_wr)
      |=> mode == pwr_mode_pkg::ST_ACTIVE)
      else $error("mode left without request");
   // Hibernate resume must stay strictly below the bound
   AST_HIB_WAKE_BOUND: assert property (@(posedge ref_clk) disable iff (rst)
      (mode == pwr_mode_pkg::ST_WAKE && from_hib) |-> wake_cycles < 16'(HIB_CYC))
      else $error("hibernate resume too long");
   AST_SLEEP_WAKE_MIN: assert property (@(posedge ref_clk) disable iff (rst)
      (mode == pwr_mode_pkg::ST_WAKE && !from_hib && wake_cycles < 16'(SLEEP_CYC))
      |=> mode == pwr_mode_pkg::ST_WAKE)
      else $error("sleep resume ended early");
   AST_SLEEP_WAKE_MAX: assert property (@(posedge ref_clk) disable iff (rst)
      (mode == pwr_mode_pkg::ST_WAKE && !from_hib)
      |-> wake_cycles <= 16'(SLEEP_CYC + 1))
      else $error("sleep resume too long");
endmodule
`default_nettype wire

/* File: test/power_mode_controller_tb_top.sv */
// Testbench for power_mode_controller: modes, wakeup paths, boost control.
// Assumes registered outputs on ref_clk and shortened wake counts.
`timescale 1ns/1ps
`default_nettype none
module power_mode_controller_tb_top;
   localparam int SLP = 20;
   localparam int HIB = 30;
   localparam logic [2:0] M_ACT = pwr_mode_pkg::ST_ACTIVE;
   localparam logic [2:0] M_ALT = pwr_mode_pkg::ST_ALT;
   localparam logic [2:0] M_SLP = pwr_mode_pkg::ST_SLEEP;
   localparam logic [2:0] M_HIB = pwr_mode_pkg::ST_HIB;
   logic        ref_clk, rst, mode_req_wr, cpu_off_req;
   logic [15:0] active_template, alt_template, res_enable, clk_gate_en;
   logic [1:0]  mode_req, startup_osc_sel;
   logic [7:0]  irq_pending, irq_enable;
   logic        supervisor_irq, timewheel_irq, pin_irq, external_reset_pin_n;
   logic        watchdog_timer, precise_low_voltage_reset, boost_standby_req;
   logic        fast_startup, cpu_enable, retain_hold, boost_active, boost_clk;
   logic [5:0]  boost_vsel, boost_code;
   logic [2:0]  global_mode;
   int          err_count, checks_done, n, hi;

   power_mode_controller #(.N_RES(16), .N_IRQ(8), .SLEEP_CYC(SLP), .HIB_CYC(HIB))
   u_power_mode_controller (
      .ref_clk                   (ref_clk),
      .rst                       (rst),
      .active_template           (active_template),
      .alt_template              (alt_template),
      .mode_req                  (mode_req),
      .mode_req_wr               (mode_req_wr),
      .cpu_off_req               (cpu_off_req),
      .irq_pending               (irq_pending),
      .irq_enable                (irq_enable),
      .supervisor_irq            (supervisor_irq),
      .timewheel_irq             (timewheel_irq),
      .pin_irq                   (pin_irq),
      .external_reset_pin_n      (external_reset_pin_n),
      .watchdog_timer            (watchdog_timer),
      .precise_low_voltage_reset (precise_low_voltage_reset),
      .boost_vsel                (boost_vsel),
      .boost_standby_req         (boost_standby_req),
      .fast_startup              (fast_startup),
      .global_mode               (global_mode),
      .res_enable                (res_enable),
      .clk_gate_en               (clk_gate_en),
      .cpu_enable                (cpu_enable),
      .retain_hold               (retain_hold),
      .boost_code                (boost_code),
      .boost_active              (boost_active),
      .boost_clk                 (boost_clk),
      .startup_osc_sel           (startup_osc_sel)
   );

   initial
   begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   task automatic tick(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic check_vec(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic check_rng(input string name, input int lo, input int hi_b, input int got);
      checks_done++;
      if (got < lo || got > hi_b)
      begin
         err_count++;
         $display("[FAIL] %s expected %0d..%0d seen %0d", name, lo, hi_b, got);
      end
   endtask

   task automatic wait_mode(input logic [2:0] m, input int lim, output int cnt);
      cnt = 0;
      while (global_mode !== m)
      begin
         if (cnt >= lim)
         begin
            err_count++;
            $display("[FAIL] mode wait expected %h seen %h", m, global_mode);
            summarize();
         end
         tick(1);
         cnt++;
      end
   endtask

   task automatic half_period(output int cnt);
      logic b;
      b = boost_clk;
      cnt = 0;
      while (boost_clk === b && cnt < 600)
      begin
         tick(1);
         cnt++;
      end
   endtask

   task automatic req_mode(input logic [1:0] code);
      mode_req = code;
      mode_req_wr = 1'b1;
      tick(1);
      mode_req_wr = 1'b0;
      tick(2);
   endtask

   task automatic set_src(input int k, input logic v);
      case (k)
         0: irq_pending[2] = v;
         1: supervisor_irq = v;
         2: timewheel_irq = v;
         3: pin_irq = v;
         4: watchdog_timer = v;
         5: precise_low_voltage_reset = v;
         default: external_reset_pin_n = ~v;
      endcase
   endtask

   task automatic do_reset(input logic fs);
      rst = 1'b1;
      fast_startup = fs;
      tick(5);
      rst = 1'b0;
      tick(2);
      check_vec("mode after reset", 16'(M_ACT), 16'(global_mode));
      check_vec("cpu after reset", 16'h0001, 16'(cpu_enable));
      check_vec("startup osc", 16'(fs ? pwr_mode_pkg::OSC_SEL_48 : pwr_mode_pkg::OSC_SEL_12),
                16'(startup_osc_sel));
   endtask

   initial
   begin
      err_count = 0;
      checks_done = 0;
      rst = 1'b1;
      active_template = 16'hA5C3;
      alt_template = 16'h3C5A;
      {mode_req, mode_req_wr, cpu_off_req} = '0;
      irq_pending = 8'h00;
      irq_enable = 8'h04;
      {supervisor_irq, timewheel_irq, pin_irq, watchdog_timer} = '0;
      precise_low_voltage_reset = 1'b0;
      external_reset_pin_n = 1'b1;
      boost_vsel = 6'h11;
      {boost_standby_req, fast_startup} = '0;
      do_reset(1'b0);
      do_reset(1'b1);
      check_vec("active enables", 16'hA5C3, res_enable);
      active_template = 16'h0F0F;
      tick(2);
      check_vec("active enables", 16'h0F0F, res_enable);
      check_vec("clock enables", 16'h0F0F, clk_gate_en);
      foreach (boost_vsel[i])
      begin
         boost_vsel = i[0] ? 6'h28 : 6'(i * 5);
         tick(2);
         check_vec("boost code", i[0] ? 16'h0020 : 16'(i * 5), 16'(boost_code));
      end
      boost_standby_req = 1'b1;
      tick(2);
      check_vec("boost active", 16'h0001, 16'(boost_active));
      half_period(n);
      half_period(n);
      check_rng("boost half period", pwr_mode_pkg::BOOST_HALF_CYC,
                pwr_mode_pkg::BOOST_HALF_CYC, n);
      req_mode(2'h0);
      check_vec("zero request", 16'(M_ACT), 16'(global_mode));
      req_mode(pwr_mode_pkg::REQ_ALT);
      check_vec("alt mode", 16'(M_ALT), 16'(global_mode));
      check_vec("alt enables", 16'h3C5A, res_enable);
      set_src(1, 1'b1);
      wait_mode(M_ACT, SLP + 20, n);
      check_vec("cpu after alt wake", 16'h0001, 16'(cpu_enable));
      set_src(1, 1'b0);
      cpu_off_req = 1'b1;
      tick(1);
      cpu_off_req = 1'b0;
      tick(2);
      check_vec("cpu self off", 16'h0000, 16'(cpu_enable));
      set_src(2, 1'b1);
      for (n = 0; cpu_enable !== 1'b1 && n < SLP + 20; n++) tick(1);
      check_vec("cpu back on", 16'h0001, 16'(cpu_enable));
      set_src(2, 1'b0);
      req_mode(pwr_mode_pkg::REQ_SLEEP);
      check_vec("boost standby", 16'h0000, 16'(boost_active));
      irq_pending[5] = 1'b1;
      hi = 0;
      repeat (600)
      begin
         tick(1);
         hi += int'(boost_clk === 1'b1);
      end
      check_rng("boost clk idle", 0, 0, hi);
      check_vec("masked irq", 16'(M_SLP), 16'(global_mode));
      irq_pending[5] = 1'b0;
      for (int k = 0; k < 7; k++)
      begin
         if (k > 0)
            req_mode(pwr_mode_pkg::REQ_SLEEP);
         check_vec("sleep mode", 16'(M_SLP), 16'(global_mode));
         check_vec("sleep enables", 16'h0000, res_enable);
         set_src(k, 1'b1);
         wait_mode(M_ACT, SLP + 20, n);
         check_rng("sleep wake time", SLP, SLP + 8, n);
         check_vec("cpu after wake", 16'h0001, 16'(cpu_enable));
         check_vec("boost after wake", 16'h0001, 16'(boost_active));
         set_src(k, 1'b0);
         tick(2);
      end
      req_mode(pwr_mode_pkg::REQ_HIB);
      check_vec("hib retention", 16'h0001, 16'(retain_hold));
      check_vec("hib boost", 16'h0001, 16'(boost_active));
      for (int k = 0; k < 6; k++)
         if (k != 3)
            set_src(k, 1'b1);
      tick(HIB + 20);
      check_vec("hib ignores others", 16'(M_HIB), 16'(global_mode));
      for (int k = 0; k < 6; k++)
         set_src(k, 1'b0);
      tick(2);
      set_src(3, 1'b1);
      wait_mode(M_ACT, HIB + 20, n);
      check_rng("hib wake time", 1, HIB + 2, n);
      check_vec("retention released", 16'h0000, 16'(retain_hold));
      set_src(3, 1'b0);
      tick(2);
      summarize();
   end
endmodule
`default_nettype wire
